// ==== hdl/srfe_rx_front.sv ====
// Serial receive front end: sync detect, deserialiser, carrier end and recovery.
// Assumes decoder keeps its obligations on preamble, clean bits and tail clocks.
`timescale 1ns/10ps
`default_nettype none
`include "srfe_map.svh"
module srfe_rx_front
    import srfe_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_rx_bit_clock,
    input  wire logic        i_rx_data,
    input  wire logic        i_carrier_sense_in,
    output logic [7:0]       o_byte,
    output logic             o_byte_stb,
    output logic [15:0]      o_byte_cnt,
    output logic             o_frame_active,
    output logic             o_frame_end,
    output logic             o_dribble_err,
    output logic             o_ready
);
    srfe_edge_if ev ();

    srfe_pin_sync u_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_bit_clk (i_rx_bit_clock),
        .i_rxd     (i_rx_data),
        .i_carrier (i_carrier_sense_in),
        .o_edge    (ev)
    );

    srfe_state_t state_q, state_d;
    logic        prev_q, prev_d;
    logic [7:0]  shift_q, shift_d;
    logic [2:0]  bit_q, bit_d;
    logic [2:0]  low_q, low_d;
    logic [2:0]  tail_q, tail_d;
    logic [5:0]  rec_q, rec_d;
    logic [7:0]  byte_q, byte_d;
    logic        stb_q, stb_d;
    logic [15:0] cnt_q, cnt_d;
    logic        end_q, end_d;
    logic        derr_q, derr_d;

    always_comb
    begin
        state_d = state_q;
        prev_d  = prev_q;
        shift_d = shift_q;
        bit_d   = bit_q;
        low_d   = low_q;
        tail_d  = tail_q;
        rec_d   = rec_q;
        byte_d  = byte_q;
        stb_d   = 1'b0;
        cnt_d   = cnt_q;
        end_d   = 1'b0;
        derr_d  = derr_q;
        if (ev.rise)
        begin
            // Carrier low samples counted on bit clocks only
            low_d = ev.carrier ? 3'h0 : ((low_q == `SRFE_CARRIER_END_CNT) ? low_q : low_q + 3'h1); // RL6
        end
        case (state_q)
            SRFE_IDLE:
            begin
                prev_d = 1'b0;
                if (ev.carrier)
                begin
                    state_d = SRFE_HUNT;
                    derr_d  = 1'b0;
                    cnt_d   = `SRFE_BYTE_CNT_RST;
                end
            end
            SRFE_HUNT:
            begin
                if (ev.rise)
                begin
                    prev_d = ev.data;
                    if (prev_q & ev.data)  // RL2
                    begin
                        state_d = SRFE_DATA;
                        bit_d   = 3'h0;
                    end
                    else if (low_d == `SRFE_CARRIER_END_CNT)
                    begin
                        state_d = SRFE_IDLE;
                    end
                end
            end
            SRFE_DATA, SRFE_TAIL:
            begin
                if (ev.rise)
                begin
                    if (state_q == SRFE_DATA)
                    begin
                        // Shifts up to the second low carrier sample, so a late final bit is kept
                        shift_d = {ev.data, shift_q[7:1]};  // RL11 RL7
                        bit_d   = bit_q + 3'h1;
                        if (bit_q == `SRFE_BITS_PER_BYTE)   // RL10
                        begin
                            byte_d = shift_d;
                            stb_d  = 1'b1;
                            cnt_d  = cnt_q + 16'h0001;
                        end
                        tail_d = 3'h0;
                        if (low_d == `SRFE_CARRIER_END_CNT) // RL6
                        begin
                            state_d = SRFE_TAIL;
                        end
                    end
                    else
                    begin
                        // Tail clocks carry no data: no spurious byte from them
                        tail_d = tail_q + 3'h1;
                        if (ev.carrier)
                        begin
                            state_d = SRFE_DATA;
                        end
                        else if (tail_d == `SRFE_TAIL_CLKS)
                        begin
                            // Partial byte beyond the dribble allowance flags error
                            derr_d  = (bit_q > `SRFE_DRIBBLE_MAX); // RL8
                            end_d   = 1'b1;
                            rec_d   = 6'h00;
                            state_d = SRFE_RECOVER;
                        end
                    end
                end
            end
            SRFE_RECOVER:
            begin
                // Recovery of forty i_ref_clk cycles from the next bit clock, well inside the allowed forty bit clocks
                if (ev.rise | (rec_q != 6'h00))
                begin
                    rec_d = rec_q + 6'h01;
                end
                if (rec_q == `SRFE_RECOVERY_CNT - 6'h01)  // RL9
                begin
                    state_d = SRFE_IDLE;
                end
            end
            default:
            begin
                state_d = SRFE_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            state_q <= SRFE_IDLE;
            prev_q  <= 1'b0;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            low_q   <= 3'h0;
            tail_q  <= 3'h0;
            rec_q   <= 6'h00;
            byte_q  <= 8'h00;
            stb_q   <= 1'b0;
            cnt_q   <= `SRFE_BYTE_CNT_RST;
            end_q   <= 1'b0;
            derr_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            prev_q  <= prev_d;
            shift_q <= shift_d;
            bit_q   <= bit_d;
            low_q   <= low_d;
            tail_q  <= tail_d;
            rec_q   <= rec_d;
            byte_q  <= byte_d;
            stb_q   <= stb_d;
            cnt_q   <= cnt_d;
            end_q   <= end_d;
            derr_q  <= derr_d;
        end
    end

    logic act_q;
    logic rdy_q;
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            act_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else
        begin
            act_q <= (state_d == SRFE_DATA) | (state_d == SRFE_TAIL);
            rdy_q <= (state_d == SRFE_IDLE);
        end
    end

    assign o_byte         = byte_q;
    assign o_byte_stb     = stb_q;
    assign o_byte_cnt     = cnt_q;
    assign o_frame_active = act_q;
    assign o_frame_end    = end_q;
    assign o_dribble_err  = derr_q;
    assign o_ready        = rdy_q;
endmodule // srfe_rx_front
`default_nettype wire

// ==== hdl/srfe_map.svh ====
// Constants for the serial receive front end: counts in receive-clock cycles, except recovery in i_ref_clk cycles.
// Assumes inclusion by bare name from hdl/ files.
// Functional notes
// RL1 - Receive data is captured on the rising edge of the bit clock.
// RL2 - Two consecutive received ones declare frame sync, anywhere in the stream; core looks for them only in SRFE_HUNT, after carrier is seen.
// RL3 - Decoder gives at least eight preamble clocks before sync.
// RL4 - Decoder presents only good bits; gates clock or carrier while locking.
// RL5 - Decoder supplies at least five full clocks after carrier drops; core needs seven (two low samples plus five tail clocks).
// RL6 - Carrier ends only after two consecutive low carrier samples.
// RL7 - Final bit is always loaded when carrier falls within one clock.
// RL8 - Trailing dribble clocks are tolerated without a receive error; core flags o_dribble_err past five partial-byte bits.
// RL9 - End-of-frame processing finishes within forty receive clocks.
// RL10 - After sync every eight bits form a byte, strobed and counted.
// RL11 - Data shifts only under carrier or its trailing clocks.
`ifndef SRFE_MAP_SVH
`define SRFE_MAP_SVH
`define SRFE_CARRIER_END_CNT 3'h2
`define SRFE_DRIBBLE_MAX    3'h5
`define SRFE_TAIL_CLKS      3'h5
`define SRFE_RECOVERY_CNT   6'h28
`define SRFE_BITS_PER_BYTE  3'h7
`define SRFE_BYTE_CNT_RST   16'h0000
`endif

// ==== hdl/srfe_pkg.sv ====
// Types of the serial receive front end.
// Assumes nothing beyond a SystemVerilog compiler.
package srfe_pkg;
    typedef enum logic [2:0]
    {
        SRFE_IDLE    = 3'b000,
        SRFE_HUNT    = 3'b001,
        SRFE_DATA    = 3'b011,
        SRFE_TAIL    = 3'b010,
        SRFE_RECOVER = 3'b110
    } srfe_state_t;
endpackage

// ==== hdl/srfe_edge_if.sv ====
// Interface carrying sampled link pins from the synchroniser to the core.
// Assumes a single system clock domain.
`timescale 1ns/10ps
`default_nettype none
interface srfe_edge_if;
    logic rise;
    logic data;
    logic carrier;
    modport src (output rise, output data, output carrier);
    modport dst (input rise, input data, input carrier);
endinterface
`default_nettype wire

// ==== hdl/srfe_pin_sync.sv ====
// Triple-flop sampler of the bit clock, data and carrier pins.
// Assumes pins asynchronous to i_ref_clk; a change counts when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module srfe_pin_sync
    import srfe_pkg::*;
(
    input  wire logic  i_ref_clk,
    input  wire logic  i_sys_rst,
    input  wire logic  i_bit_clk,
    input  wire logic  i_rxd,
    input  wire logic  i_carrier,
    srfe_edge_if.src   o_edge
);
    logic [2:0] s1_q, s1_d;
    logic [2:0] s2_q, s2_d;
    logic [2:0] s3_q, s3_d;
    logic [2:0] st_q, st_d;
    logic       rise_q, rise_d;
    logic       dat_q, dat_d;

    always_comb
    begin
        s1_d   = {i_carrier, i_rxd, i_bit_clk};
        s2_d   = s1_q;
        s3_d   = s2_q;
        st_d   = st_q;
        for (int i = 0; i < 3; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                st_d[i] = s3_q[i];
            end
        end
        // Data held with the edge: setup before the clock edge favours old sample
        rise_d = st_d[0] & ~st_q[0];        // RL1
        dat_d  = rise_d ? st_q[1] : dat_q;  // RL1
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            s3_q   <= 3'h0;
            st_q   <= 3'h0;
            rise_q <= 1'b0;
            dat_q  <= 1'b0;
        end
        else
        begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            st_q   <= st_d;
            rise_q <= rise_d;
            dat_q  <= dat_d;
        end
    end

    assign o_edge.rise = rise_q;
    assign o_edge.data = dat_q;
    assign o_edge.carrier = st_q[2];
endmodule // srfe_pin_sync
`default_nettype wire

// ==== verif/srfe_rx_front_props.sv ====
// Port checker of the serial receive front end.
// Assumes binding to srfe_rx_front; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module srfe_rx_front_props
(
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_carrier_sense_in,
    input wire logic        o_byte_stb,
    input wire logic [15:0] o_byte_cnt,
    input wire logic        o_frame_active,
    input wire logic        o_frame_end,
    input wire logic        o_dribble_err,
    input wire logic        o_ready
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    property p_stb_pulse; o_byte_stb |=> !o_byte_stb; endproperty
    a_stb_pulse: assert property (p_stb_pulse) else $error("byte strobe too long");
    property p_cnt_step; o_byte_stb |-> o_byte_cnt == $past(o_byte_cnt) + 16'h1; endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("byte count not stepped");
    property p_end_pulse; o_frame_end |=> !o_frame_end; endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("frame end too long");
    property p_recover; o_frame_end |-> ##[1:640] o_ready; endproperty
    a_recover: assert property (p_recover) else $error("recovery too slow");
    // Tail alone spans more than 64 cycles of low carrier
    property p_crs_end; o_frame_end |-> !i_carrier_sense_in && !$past(i_carrier_sense_in, 64); endproperty
    a_crs_end: assert property (p_crs_end) else $error("frame ended under carrier");
    property p_no_idle_stb; o_ready |-> !o_byte_stb; endproperty
    a_no_idle_stb: assert property (p_no_idle_stb) else $error("byte while idle");
    property p_sync_crs; $rose(o_frame_active) |-> i_carrier_sense_in; endproperty
    a_sync_crs: assert property (p_sync_crs) else $error("sync without carrier");
    property p_busy; o_frame_active |-> !o_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready during frame");
    property p_drib_end; $rose(o_dribble_err) |-> o_frame_end; endproperty
    a_drib_end: assert property (p_drib_end) else $error("dribble flag off frame end");
endmodule // srfe_rx_front_props
bind srfe_rx_front srfe_rx_front_props u_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_carrier_sense_in(i_carrier_sense_in), .o_byte_stb(o_byte_stb), .o_byte_cnt(o_byte_cnt),
    .o_frame_active(o_frame_active), .o_frame_end(o_frame_end), .o_dribble_err(o_dribble_err),
    .o_ready(o_ready));
`default_nettype wire

// ==== verif/srfe_dec_model.sv ====
// Model of the external decoder driving bit clock, data and carrier.
// Assumes the bench calls its tasks; clock stands still between calls.
`timescale 1ns/10ps
`default_nettype none
module srfe_dec_model
(
    output logic o_bit_clk,
    output logic o_rxd,
    output logic o_carrier
);
    initial
    begin
        o_bit_clk = 1'b0;
        o_rxd     = 1'b0;
        o_carrier = 1'b0;
    end
    // Data held 60 ns past the rise
    task automatic send(input logic d, input logic c);
        o_rxd = d;
        o_carrier = c;
        #20 o_bit_clk = 1'b1;
        #40 o_bit_clk = 1'b0;
        #20;
    endtask
    task automatic trail();
        int i;
        for (i = 0; i < 10; i++)
            send(~o_rxd, 1'b0);
        o_rxd = ~o_rxd;
    endtask
endmodule // srfe_dec_model
`default_nettype wire

// ==== verif/srfe_rx_front_tb.sv ====
// Self-checking bench of the serial receive front end.
// Assumes the decoder model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module srfe_rx_front_tb;
    import srfe_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    wire logic   bit_clk;
    wire logic   rxd;
    wire logic   carrier;
    logic [7:0]  o_byte;
    logic        o_stb;
    logic [15:0] o_cnt;
    logic        o_act;
    logic        o_end;
    logic        o_derr;
    logic        o_ready;
    logic [7:0]  exp_b;
    logic [7:0]  exp_q[$];
    int          mismatches = 0;
    int          checked = 0;
    int          ends = 0;
    int          seed = 32'ha9f2;
    srfe_dec_model dec (.o_bit_clk(bit_clk), .o_rxd(rxd), .o_carrier(carrier));
    srfe_rx_front dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_rx_bit_clock(bit_clk), .i_rx_data(rxd),
        .i_carrier_sense_in(carrier), .o_byte(o_byte), .o_byte_stb(o_stb), .o_byte_cnt(o_cnt),
        .o_frame_active(o_act), .o_frame_end(o_end), .o_dribble_err(o_derr), .o_ready(o_ready));
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Sampled mid-cycle, clear of the launching edge
    always @(negedge ref_clk)
    begin
        if (o_end === 1'b1)
            ends++;
        if (o_stb === 1'b1 && exp_q.size() == 0)
            `CHK(o_stb, 1'b0)
        else if (o_stb === 1'b1)
        begin
            exp_b = exp_q.pop_front();
            `CHK(o_byte, exp_b)
        end
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic frame(input int n, input int drib, input int gl, input int k);
        logic [7:0] b;
        int         i;
        @(negedge ref_clk);
        #1.3;
        dec.send(1'b1, 1'b0);
        dec.send(1'b1, 1'b0);
        for (i = 0; i < 8; i++)
            dec.send(~i[0], 1'b1);
        dec.send(1'b1, 1'b1);
        dec.send(1'b1, 1'b1);
        for (i = 0; i < n * 8; i++)
        begin
            if (i % 8 == 0)
            begin
                b = $random(seed);
                exp_q.push_back(b);
            end
            dec.send(b[i % 8], i != gl);
        end
        for (i = 0; i < drib; i++)
            dec.send(i[0], 1'b1);
        dec.trail();
        for (i = 0; i < 2000 && o_ready !== 1'b1; i++)
            @(negedge ref_clk);
        if (i == 2000)
        begin
            mismatches++;
            end_of_test();
        end
        else
        begin
            `CHK(exp_q.size(), 0)
            `CHK(o_cnt, 16'(n))
            `CHK(o_derr, 1'b0)
            `CHK(ends, k)
            $display("frame of %0d bytes done", n);
        end
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK(o_ready, 1'b1)
        frame(3, 0, -1, 1);
        frame(4, 3, -1, 2);
        frame(2, 0, 9, 3);
        end_of_test();
    end
endmodule // srfe_rx_front_tb
`default_nettype wire
